//--- design/wpan_rx_pkg.sv
package wpan_rx_pkg;

  // ***********************************************
  // configuration words
  // ***********************************************
  // receive-queue entry shaping, bit 0 is the last member
  typedef struct packed {
    logic add_rx_time;
    logic add_source_match_index;
    logic add_corr_check_byte;
    logic add_signal_strength_byte;
    logic keep_fcs_field;
    logic keep_phy_header;
    logic drop_filtered_pkts;
    logic drop_crc_fail_pkts;
  } rxq_cfg_type;

  // clear-channel assessment options, bit 7 reserved
  typedef struct packed {
    logic reserved7;
    logic [1:0] corr_peak_threshold;
    logic sync_combine_sel;
    logic energy_corr_combine_sel;
    logic chan_sync_src_on;
    logic chan_corr_src_on;
    logic chan_energy_src_on;
  } cca_cfg_type;

  // frame filtering options
  typedef struct packed {
    logic exact_ack_length;
    logic [1:0] type_msb_adjust;
    logic [2:0] ctrl_reserved_mask;
    logic [1:0] version_limit;
    logic is_network_coordinator;
    logic pending_datareq_only;
    logic fallback_pending_bit;
    logic auto_pending_on;
    logic slot_aligned_ack;
    logic auto_acknowledge_on;
    logic abort_on_reject;
    logic filter_on;
  } filt_cfg_type;

  // ***********************************************
  // per-frame side information, valid with the end byte
  // ***********************************************
  typedef struct packed {
    logic crc_ok;
    logic [7:0] rssi;
    logic [6:0] corr;
    logic [7:0] src_index;
    logic [31:0] timestamp;
    logic is_datareq;
    logic src_pend;
  } rx_info_type;

  // one receive-queue word
  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic drop;
  } q_word_type;

  localparam int QW_WIDTH = $bits(q_word_type);
  localparam int QUEUE_DEPTH = 8;

  // ***********************************************
  // codes and counts
  // ***********************************************
  localparam logic [1:0] CCA_IDLE = 2'h0;
  localparam logic [1:0] CCA_BUSY = 2'h1;
  localparam logic [1:0] CCA_INVALID = 2'h2;
  localparam logic [1:0] MSB_KEEP = 2'h0;
  localparam logic [1:0] MSB_INVERT = 2'h1;
  localparam logic [1:0] MSB_CLEAR = 2'h2;
  localparam logic [1:0] MSB_SET = 2'h3;
  localparam logic [2:0] FT_DATA = 3'h1;
  localparam logic [2:0] FT_ACK = 3'h2;
  localparam logic [2:0] FT_CMD = 3'h3;
  localparam logic [6:0] ACK_LEN = 7'h05;
  localparam logic [7:0] IDX_PHR = 8'h00;
  localparam logic [7:0] IDX_FCF_LO = 8'h01;
  localparam logic [7:0] IDX_FCF_HI = 8'h02;
  localparam logic [7:0] IDX_SEQ = 8'h03;
  localparam logic [2:0] TR_RSSI = 3'h0;
  localparam logic [2:0] TR_CORR = 3'h1;
  localparam logic [2:0] TR_SRC = 3'h2;
  localparam logic [2:0] TR_TS0 = 3'h3;
  localparam logic [2:0] TR_NONE = 3'h7;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_FRAME = 3'b001,
    S_TRAIL = 3'b010,
    S_TERM = 3'b011,
    S_SKIP = 3'b100
  } rx_state_type;

endpackage : wpan_rx_pkg

//--- design/wpan_rx_filter_cca_config.sv
`timescale 1ns/1ps
// Function
// - queue config bit 0 drops frames that failed the CRC check
// - queue config bit 1 drops frames the filter marked ignorable
// - queue config bit 2 keeps the PHY header byte, else strips it
// - queue config bit 3 keeps the CRC field; host sets it only with CRC on
// - queue config bit 4 appends a signal strength byte
// - queue config bit 5 appends a correlation plus CRC result byte
// - queue config bit 6 appends the source match index
// - queue config bit 7 appends the reception timestamp
// - channel config bits 0..2 enable energy, correlator and sync sources
// - channel config bit 3: either busy (0) or both busy (1)
// - channel config bit 4: sync busy forces busy (0) or idle forces idle (1)
// - channel config bits 5..6 set the correlation peak count that must be exceeded for busy
// - filter bit 0 enables filtering, bit 1 aborts reception on reject
// - filter bit 2 enables auto ack; undecided pending bit equals bit 5
// - filter bit 4 enables auto pending, bit 6 limits it to data requests
// - filter bit 7 marks coordinator role, used in acceptance
// - reject frames whose version exceeds filter bits 8..9
// - reject frames whose reserved control bits AND mask bits 10..12 nonzero
// - bits 13..14 keep, invert, clear or set the top frame type bit
// - bit 15: acks of five or more bytes, or exactly five bytes
// - type mask accepts types 0..7; ack receive admits masked acks
// - combined channel state: 00 idle, 01 busy, 10 invalid

// ***********************************************
// receive queue buffer
// ***********************************************
module wpan_rx_queue_fifo
#(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [$clog2(DEPTH+1)-1:0] next_level;
  logic push;
  logic pop;

  // handshakes; full and empty come from the level alone
  assign in_ready = (level != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and level update
  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_level = level;
    if (push)
    begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_level = level + 1'b1;
    end
    else if (pop && !push)
    begin
      next_level = level - 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level <= next_level;
    end
  end

  // storage carries no reset, only the pointers matter
  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : wpan_rx_queue_fifo

// ***********************************************
// receive filter, queue shaping and channel assessment
// ***********************************************
module wpan_rx_filter_cca_config
  import wpan_rx_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // configuration words
  input wire rxq_cfg_type rxq_cfg,
  input wire cca_cfg_type cca_cfg,
  input wire filt_cfg_type filt_cfg,
  input wire logic [7:0] frame_type_mask,
  input wire logic fcs_check_on,
  input wire logic ack_rx_active,
  // demodulated byte stream
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_sof,
  input wire logic in_eof,
  input wire rx_info_type rx_info,
  output logic in_ready,
  // receive queue
  output logic q_valid,
  output q_word_type q_word,
  input wire logic q_ready,
  // auto acknowledge request
  output logic ack_req,
  output logic ack_pending,
  output logic [7:0] ack_seq,
  // filter events
  output logic frame_rejected,
  output logic rx_abort,
  // channel assessment sources and result
  input wire logic [1:0] energy_busy_result,
  input wire logic corr_peak,
  input wire logic corr_window_clear,
  input wire logic sync_busy_result,
  output logic corr_busy_result,
  output logic [1:0] chan_assess_state
);
  localparam int LW = $clog2(DEPTH+1);

  rx_state_type state, next_state;
  logic [7:0] idx, next_idx;
  logic [6:0] len, next_len;
  logic [7:0] fcf_lo, next_fcf_lo;
  logic rejected, next_rejected;
  logic [7:0] hold0, next_hold0;
  logic [7:0] hold1, next_hold1;
  logic [1:0] hcnt, next_hcnt;
  rx_info_type info, next_info;
  logic [2:0] tsel, next_tsel;
  logic tdrop, next_tdrop;
  logic next_in_ready;
  logic next_ack_req, next_ack_pending;
  logic [7:0] next_ack_seq;
  logic next_frame_rejected, next_rx_abort;
  logic push_valid, push_ready;
  q_word_type push_word;
  logic [LW-1:0] level;
  logic [2:0] corr_cnt, next_corr_cnt;
  logic next_corr_busy;
  logic [1:0] next_chan_state;

  // lowest enabled trailer at or after position from
  function automatic logic [2:0] trail_from(input logic [6:0] en, input logic [2:0] from);
    logic [2:0] sel;
    sel = TR_NONE;
    for (int i = 6; i >= 0; i--)
    begin
      if (en[i] && (3'(i) >= from))
      begin
        sel = 3'(i);
      end
    end
    return sel;
  endfunction : trail_from

  // ***********************************************
  // frame path
  // ***********************************************
  always_comb
  begin
    logic byte_ok;
    logic strip;
    logic [6:0] tr_en;
    logic [2:0] ft;
    logic rej;
    logic drop;
    logic [2:0] first_tr;
    logic emit;
    logic [7:0] emit_data;
    next_state = state;
    next_idx = idx;
    next_len = len;
    next_fcf_lo = fcf_lo;
    next_rejected = rejected;
    next_hold0 = hold0;
    next_hold1 = hold1;
    next_hcnt = hcnt;
    next_info = info;
    next_tsel = tsel;
    next_tdrop = tdrop;
    next_ack_req = 1'b0;
    next_ack_pending = ack_pending;
    next_ack_seq = ack_seq;
    next_frame_rejected = 1'b0;
    next_rx_abort = 1'b0;
    push_valid = 1'b0;
    push_word = '0;
    byte_ok = in_valid && in_ready;
    // the fcs is held back two bytes so it can be stripped at the end
    strip = fcs_check_on && !(rxq_cfg.keep_fcs_field && fcs_check_on);
    tr_en = {{4{rxq_cfg.add_rx_time}}, rxq_cfg.add_source_match_index,
             rxq_cfg.add_corr_check_byte, rxq_cfg.add_signal_strength_byte};
    first_tr = trail_from(tr_en, TR_RSSI);
    ft = fcf_lo[2:0];
    unique case (filt_cfg.type_msb_adjust)
      MSB_KEEP: ft = fcf_lo[2:0];
      MSB_INVERT: ft = {~fcf_lo[2], fcf_lo[1:0]};
      MSB_CLEAR: ft = {1'b0, fcf_lo[1:0]};
      MSB_SET: ft = {1'b1, fcf_lo[1:0]};
    endcase
    // filter decision, taken when the high control byte arrives
    rej = 1'b0;
    if (in_data[5:4] > filt_cfg.version_limit)
    begin
      rej = 1'b1;
    end
    if (({in_data[1:0], fcf_lo[7]} & filt_cfg.ctrl_reserved_mask) != 3'h0)
    begin
      rej = 1'b1;
    end
    if (!frame_type_mask[ft] && !(ft == FT_ACK && ack_rx_active))
    begin
      rej = 1'b1;
    end
    if (ft == FT_ACK && (len < ACK_LEN || (filt_cfg.exact_ack_length && len != ACK_LEN)))
    begin
      rej = 1'b1;
    end
    // a data or command frame with no destination is only for the coordinator
    if ((ft == FT_DATA || ft == FT_CMD) && in_data[3:2] == 2'h0
        && !filt_cfg.is_network_coordinator)
    begin
      rej = 1'b1;
    end
    rej = rej && filt_cfg.filter_on;
    drop = (rxq_cfg.drop_crc_fail_pkts && !rx_info.crc_ok)
      || (rxq_cfg.drop_filtered_pkts && rejected);
    emit = 1'b0;
    emit_data = in_data;
    unique case (state)
      S_IDLE, S_FRAME:
      begin
        if (byte_ok && (in_sof || state == S_FRAME))
        begin
          next_idx = in_sof ? 8'h01 : ((idx == 8'hFF) ? idx : idx + 1'b1);
          if (in_sof)
          begin
            next_state = S_FRAME;
            next_len = in_data[6:0];
            next_rejected = 1'b0;
            next_hcnt = 2'h0;
            emit = rxq_cfg.keep_phy_header;
          end
          else
          begin
            if (idx == IDX_FCF_LO)
            begin
              next_fcf_lo = in_data;
            end
            if (idx == IDX_FCF_HI)
            begin
              next_rejected = rej;
              next_frame_rejected = rej;
            end
            if (idx == IDX_SEQ)
            begin
              next_ack_seq = in_data;
            end
            if (!strip)
            begin
              emit = 1'b1;
            end
            else
            begin
              next_hold0 = in_data;
              next_hold1 = hold0;
              emit = (hcnt == 2'h2);
              emit_data = hold1;
              if (hcnt != 2'h2)
              begin
                next_hcnt = hcnt + 1'b1;
              end
            end
          end
          if (!in_sof && idx == IDX_FCF_HI && rej && filt_cfg.abort_on_reject)
          begin
            // earlier words already sit in the queue, so close them off
            next_state = S_TERM;
            next_rx_abort = 1'b1;
            next_tdrop = in_eof;
            emit = 1'b0;
          end
          else if (in_eof)
          begin
            next_info = rx_info;
            next_tdrop = drop || (rxq_cfg.drop_filtered_pkts && idx == IDX_FCF_HI && rej);
            next_tsel = first_tr;
            next_state = (first_tr == TR_NONE) ? S_IDLE : S_TRAIL;
            next_ack_req = filt_cfg.auto_acknowledge_on && rx_info.crc_ok && fcf_lo[5]
              && !rejected && ft != FT_ACK;
            if (filt_cfg.auto_pending_on
                && (!filt_cfg.pending_datareq_only || rx_info.is_datareq))
            begin
              next_ack_pending = rx_info.src_pend;
            end
            else
            begin
              next_ack_pending = filt_cfg.fallback_pending_bit;
            end
          end
          push_valid = emit || (in_eof && first_tr == TR_NONE && next_state == S_IDLE);
          push_word.data = emit ? emit_data : 8'h00;
          push_word.last = in_eof && first_tr == TR_NONE;
          push_word.drop = in_eof && first_tr == TR_NONE && next_tdrop;
        end
      end
      S_TRAIL:
      begin
        push_valid = 1'b1;
        push_word.last = (trail_from(tr_en, tsel + 1'b1) == TR_NONE) || tsel == 3'h6;
        push_word.drop = push_word.last && tdrop;
        unique case (tsel)
          3'h0: push_word.data = info.rssi;
          3'h1: push_word.data = {info.crc_ok, info.corr};
          3'h2: push_word.data = info.src_index;
          3'h3: push_word.data = info.timestamp[7:0];
          3'h4: push_word.data = info.timestamp[15:8];
          3'h5: push_word.data = info.timestamp[23:16];
          default: push_word.data = info.timestamp[31:24];
        endcase
        if (push_ready)
        begin
          next_tsel = push_word.last ? TR_NONE : trail_from(tr_en, tsel + 1'b1);
          next_state = push_word.last ? S_IDLE : S_TRAIL;
        end
      end
      S_TERM:
      begin
        // empty closing word marks the aborted frame for removal
        push_valid = 1'b1;
        push_word.last = 1'b1;
        push_word.drop = 1'b1;
        if (push_ready)
        begin
          next_state = tdrop ? S_IDLE : S_SKIP;
        end
      end
      S_SKIP:
      begin
        if (byte_ok && in_eof)
        begin
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
    // ready lags one cycle, so leave room for the word already in flight
    next_in_ready = (next_state == S_IDLE || next_state == S_FRAME || next_state == S_SKIP)
      && (level <= LW'(DEPTH - 3));
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state <= S_IDLE;
      idx <= 8'h00;
      len <= 7'h00;
      fcf_lo <= 8'h00;
      rejected <= 1'b0;
      hold0 <= 8'h00;
      hold1 <= 8'h00;
      hcnt <= 2'h0;
      info <= '0;
      tsel <= TR_NONE;
      tdrop <= 1'b0;
      in_ready <= 1'b0;
      ack_req <= 1'b0;
      ack_pending <= 1'b0;
      ack_seq <= 8'h00;
      frame_rejected <= 1'b0;
      rx_abort <= 1'b0;
    end
    else
    begin
      state <= next_state;
      idx <= next_idx;
      len <= next_len;
      fcf_lo <= next_fcf_lo;
      rejected <= next_rejected;
      hold0 <= next_hold0;
      hold1 <= next_hold1;
      hcnt <= next_hcnt;
      info <= next_info;
      tsel <= next_tsel;
      tdrop <= next_tdrop;
      in_ready <= next_in_ready;
      ack_req <= next_ack_req;
      ack_pending <= next_ack_pending;
      ack_seq <= next_ack_seq;
      frame_rejected <= next_frame_rejected;
      rx_abort <= next_rx_abort;
    end
  end

  // queue buffer in the data path; the drain side may stall
  wpan_rx_queue_fifo #(
    .WIDTH(QW_WIDTH),
    .DEPTH(DEPTH)
  ) u_queue (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_word),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_word),
    .level(level)
  );

  // ***********************************************
  // channel assessment
  // ***********************************************
  always_comb
  begin
    logic [1:0] ec;
    logic e_on;
    logic c_on;
    ec = CCA_INVALID;
    e_on = cca_cfg.chan_energy_src_on;
    c_on = cca_cfg.chan_corr_src_on;
    next_corr_cnt = corr_cnt;
    if (corr_window_clear)
    begin
      next_corr_cnt = 3'h0;
    end
    else if (corr_peak && corr_cnt != 3'h7)
    begin
      next_corr_cnt = corr_cnt + 1'b1;
    end
    next_corr_busy = (corr_cnt > {1'b0, cca_cfg.corr_peak_threshold});
    if (e_on && c_on)
    begin
      if (energy_busy_result == CCA_INVALID)
      begin
        ec = CCA_INVALID;
      end
      else if (cca_cfg.energy_corr_combine_sel)
      begin
        ec = (energy_busy_result == CCA_BUSY && corr_busy_result) ? CCA_BUSY : CCA_IDLE;
      end
      else
      begin
        ec = (energy_busy_result == CCA_BUSY || corr_busy_result) ? CCA_BUSY : CCA_IDLE;
      end
    end
    else if (e_on)
    begin
      ec = energy_busy_result;
    end
    else if (c_on)
    begin
      ec = corr_busy_result ? CCA_BUSY : CCA_IDLE;
    end
    else
    begin
      ec = CCA_INVALID;
    end
    next_chan_state = ec;
    if (cca_cfg.chan_sync_src_on)
    begin
      if (!cca_cfg.sync_combine_sel && sync_busy_result)
      begin
        next_chan_state = CCA_BUSY;
      end
      else if (cca_cfg.sync_combine_sel && !sync_busy_result)
      begin
        next_chan_state = CCA_IDLE;
      end
      else if (ec == CCA_INVALID)
      begin
        next_chan_state = sync_busy_result ? CCA_BUSY : CCA_IDLE;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      corr_cnt <= 3'h0;
      corr_busy_result <= 1'b0;
      chan_assess_state <= CCA_INVALID;
    end
    else
    begin
      corr_cnt <= next_corr_cnt;
      corr_busy_result <= next_corr_busy;
      chan_assess_state <= next_chan_state;
    end
  end
endmodule : wpan_rx_filter_cca_config

//--- verification/rx_cfg_chk.sv
`timescale 1ns/1ps
// *****
// port checks
// *****
module rx_cfg_chk
  import wpan_rx_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // channel assessment
  input wire cca_cfg_type cca_cfg,
  input wire logic [1:0] energy_busy_result,
  input wire logic sync_busy_result,
  input wire logic corr_peak,
  input wire logic corr_window_clear,
  input wire logic corr_busy_result,
  input wire logic [1:0] chan_assess_state,
  // stream and events
  input wire logic in_ready,
  input wire logic q_valid,
  input wire logic q_ready,
  input wire q_word_type q_word,
  input wire logic ack_req,
  input wire logic frame_rejected
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  chk_reset_exit:
  assert property ($rose(resetn) |-> !in_ready && !q_valid && chan_assess_state == CCA_INVALID)
    else $error("state after reset wrong");
  chk_no_source:
  assert property (cca_cfg[2:0] == 3'h0 |=> chan_assess_state == CCA_INVALID)
    else $error("no source but state valid");
  chk_energy_only:
  assert property (cca_cfg[2:0] == 3'h1 && energy_busy_result != 2'h2
    |=> chan_assess_state == $past(energy_busy_result)) else $error("energy not followed");
  chk_sync_busy:
  assert property (cca_cfg[2] && !cca_cfg[4] && sync_busy_result && energy_busy_result != 2'h2
    |=> chan_assess_state == CCA_BUSY) else $error("sync busy not forced");
  chk_sync_idle:
  assert property (cca_cfg[2] && cca_cfg[4] && !sync_busy_result && energy_busy_result != 2'h2
    |=> chan_assess_state == CCA_IDLE) else $error("sync idle not forced");
  chk_peak_clear:
  assert property (corr_window_clear && !corr_peak ##1 !corr_peak |=> !corr_busy_result)
    else $error("peak count not cleared");
  chk_ack_pulse:
  assert property (ack_req |=> !ack_req) else $error("ack request too long");
  chk_reject_pulse:
  assert property (frame_rejected |=> !frame_rejected) else $error("reject too long");
  chk_queue_hold:
  assert property (q_valid && !q_ready |=> q_valid && $stable(q_word))
    else $error("queue word moved while stalled");
endmodule : rx_cfg_chk

bind wpan_rx_filter_cca_config rx_cfg_chk u_rx_cfg_chk (.mclk, .resetn, .cca_cfg,
  .energy_busy_result, .sync_busy_result, .corr_peak, .corr_window_clear,
  .corr_busy_result, .chan_assess_state, .in_ready, .q_valid, .q_ready, .q_word,
  .ack_req, .frame_rejected);

//--- verification/frame_source.sv
`timescale 1ns/1ps
// *****
// demodulated byte stream source
// *****
module frame_source
(
  // clock
  input wire logic mclk,
  // stream
  input wire logic in_ready,
  output logic in_valid,
  output logic [7:0] in_data,
  output logic in_sof,
  output logic in_eof
);
  logic stuck = 1'b0;
  initial
  begin
    in_valid = 1'b0;
    in_data = 8'h00;
    in_sof = 1'b0;
    in_eof = 1'b0;
  end
  // each byte held until ready is seen at an edge; ready is a register
  task automatic send(input logic [7:0] b [16], input int n);
    int i;
    int k;
    bit r;
    for (i = 0; i < n; i++)
    begin
      in_valid = 1'b1;
      in_data = b[i];
      in_sof = (i == 0);
      in_eof = (i == n - 1);
      r = 0;
      for (k = 0; k < 300 && !r; k++)
      begin
        r = (in_ready === 1'b1);
        @(posedge mclk);
        #1;
      end
      if (!r)
        stuck = 1'b1;
    end
    // released bus shows no stale byte
    in_valid = 1'b0;
    in_sof = 1'b0;
    in_eof = 1'b0;
    in_data = ~in_data;
  endtask : send
endmodule : frame_source

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import wpan_rx_pkg::*;
;
  // *****
  // signals
  // *****
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  rxq_cfg_type rxq_cfg = '0;
  cca_cfg_type cca_cfg = '0;
  filt_cfg_type filt_cfg = '0;
  logic [7:0] frame_type_mask = 8'hFF;
  logic fcs_check_on = 1'b1;
  logic ack_rx_active = 1'b0;
  logic in_valid, in_sof, in_eof, in_ready, q_valid, ack_req, ack_pending;
  logic [7:0] in_data, ack_seq;
  rx_info_type rx_info = '0;
  logic q_ready = 1'b1;
  q_word_type q_word;
  logic frame_rejected, rx_abort, corr_busy_result;
  logic [1:0] energy_busy_result = 2'h0;
  logic [1:0] chan_assess_state;
  logic corr_peak = 1'b0;
  logic corr_window_clear = 1'b0;
  logic sync_busy_result = 1'b0;
  int err_total = 0;
  int compares = 0;
  int acks = 0;
  int rejs = 0;
  int aborts = 0;
  logic pend_seen = 1'b0;
  logic [7:0] seq_seen = 8'h00;
  q_word_type got [$];
  logic [7:0] fb [16];
  localparam logic [15:0] CT [10] = '{16'h0012, 16'h0111, 16'h0100, 16'h0505, 16'h1510,
    16'h1515, 16'h0405, 16'h0B10, 16'h0311, 16'h0322};
  localparam logic [39:0] RT [9] = '{40'h0001_01_18_FF, 40'h0401_81_08_FF,
    40'h0001_04_08_EF, 40'h6001_01_08_DF, 40'h2001_04_08_FE, 40'h4001_05_08_FD,
    40'h8001_02_00_FF, 40'h0001_01_00_FF, 40'h0403_81_08_FF};
  localparam logic [15:0] PF [3] = '{16'h0054, 16'h0054, 16'h0014};
  localparam logic [7:0] EX [12] = '{8'h06, 8'h21, 8'h00, 8'h5A, 8'hC3, 8'h9C, 8'hB5,
    8'h07, 8'h11, 8'h22, 8'h33, 8'h44};

  always #5 mclk = ~mclk;

  wpan_rx_filter_cca_config u_wpan_rx_filter_cca_config (.mclk, .resetn, .rxq_cfg,
    .cca_cfg, .filt_cfg, .frame_type_mask, .fcs_check_on, .ack_rx_active, .in_valid,
    .in_data, .in_sof, .in_eof, .rx_info, .in_ready, .q_valid, .q_word, .q_ready,
    .ack_req, .ack_pending, .ack_seq, .frame_rejected, .rx_abort, .energy_busy_result,
    .corr_peak, .corr_window_clear, .sync_busy_result, .corr_busy_result,
    .chan_assess_state);

  frame_source u_frame_source (.mclk, .in_ready, .in_valid, .in_data, .in_sof, .in_eof);

  // collect queue words and event pulses
  always @(posedge mclk)
  begin
    if (q_valid === 1'b1 && q_ready === 1'b1)
      got.push_back(q_word);
    if (ack_req === 1'b1)
    begin
      acks++;
      pend_seen = ack_pending;
      seq_seen = ack_seq;
    end
    if (frame_rejected === 1'b1)
      rejs++;
    if (rx_abort === 1'b1)
      aborts++;
  end

  // *****
  // tasks
  // *****
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task results;
    $display("compares=%0d errors=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  // seven-byte frame: header, control, sequence, one payload byte, two check bytes
  task mk(input logic [7:0] lo, input logic [7:0] hi);
    fb = '{0: 8'h06, 1: lo, 2: hi, 3: 8'h5A, 4: 8'hC3, 5: 8'hAA, 6: 8'hBB, default: 8'h00};
  endtask : mk

  // a stalled queue must push back on the stream before being drained
  task frame(input bit hold);
    int k;
    got.delete();
    q_ready = !hold;
    fork
      u_frame_source.send(fb, 7);
      if (hold)
      begin
        tick(20);
        chk(in_ready, 1'b0);
        chk(q_valid, 1'b1);
        q_ready = 1'b1;
      end
    join
    for (k = 0; k < 300; k++)
    begin
      if (got.size() > 0 && got[got.size() - 1].last === 1'b1)
        break;
      tick(1);
    end
    if (k == 300 || u_frame_source.stuck)
    begin
      err_total++;
      results();
    end
    tick(2);
  endtask : frame

  // *****
  // sequence
  // *****
  initial
  begin
    int a0;
    int r0;
    tick(16);
    chk({in_ready, q_valid, ack_pending}, 3'h0);
    chk(chan_assess_state, CCA_INVALID);
    resetn = 1'b1;
    corr_window_clear = 1'b1;
    tick(1);
    corr_window_clear = 1'b0;
    foreach (CT[i])
    begin
      cca_cfg = CT[i][15:8];
      energy_busy_result = CT[i][5:4];
      sync_busy_result = CT[i][2];
      tick(3);
      chk(chan_assess_state, CT[i][1:0]);
    end
    for (int t = 0; t < 4; t++)
    begin
      cca_cfg = {1'b0, 2'(t), 5'h02};
      corr_window_clear = 1'b1;
      tick(1);
      corr_window_clear = 1'b0;
      repeat (t)
      begin
        corr_peak = 1'b1;
        tick(1);
        corr_peak = 1'b0;
        tick(1);
      end
      tick(3);
      chk({corr_busy_result, chan_assess_state}, {1'b0, CCA_IDLE});
      corr_peak = 1'b1;
      tick(1);
      corr_peak = 1'b0;
      tick(3);
      chk({corr_busy_result, chan_assess_state}, {1'b1, CCA_BUSY});
    end
    rxq_cfg = 8'hF4;
    filt_cfg = 16'h0024;
    rx_info = '{1'b1, 8'h9C, 7'h35, 8'h07, 32'h44332211, 1'b0, 1'b1};
    mk(8'h21, 8'h00);
    frame(1);
    chk(got.size(), 12);
    foreach (EX[i])
      if (i < got.size())
        chk(got[i].data, EX[i]);
    chk({got[got.size() - 1].last, got[got.size() - 1].drop}, 2'h2);
    chk({acks[7:0], pend_seen, seq_seen}, {8'h01, 1'b1, 8'h5A});
    rxq_cfg = 8'h09;
    rx_info.crc_ok = 1'b0;
    frame(0);
    chk(got.size(), 6);
    chk({got[0].data, got[got.size() - 1].data}, 16'h21BB);
    chk({got[got.size() - 1].last, got[got.size() - 1].drop}, 2'h3);
    chk(acks, 1);
    rxq_cfg = 8'h00;
    rx_info.crc_ok = 1'b1;
    foreach (PF[i])
    begin
      filt_cfg = PF[i];
      rx_info.is_datareq = (i == 1);
      frame(0);
      chk(pend_seen, i != 0);
    end
    rxq_cfg = 8'h02;
    foreach (RT[i])
    begin
      {filt_cfg, fb[1], fb[2], frame_type_mask} = RT[i];
      mk(RT[i][23:16], RT[i][15:8]);
      r0 = rejs;
      a0 = aborts;
      frame(0);
      chk(rejs - r0, 1);
      chk(aborts - a0, RT[i][25]);
      chk(got[got.size() - 1].drop, 1'b1);
    end
    // a masked-off ack still passes while an ack receive runs
    ack_rx_active = 1'b1;
    {filt_cfg, frame_type_mask} = {16'h0001, 8'hFB};
    mk(8'h02, 8'h00);
    r0 = rejs;
    frame(0);
    chk(rejs - r0, 0);
    chk(got[got.size() - 1].drop, 1'b0);
    results();
  end
endmodule : tb_top
